// *** logic/trim_ctrl_map.svh ***
// trim_ctrl_map.svh: frame field positions, codes, reset values and timing counts
// assumes: included by the package and by both ends of the serial link
`ifndef TRIM_CTRL_MAP_SVH
`define TRIM_CTRL_MAP_SVH

// frame layout
`define FRAME_BITS        24
`define FRM_RW_BIT        23
`define FRM_DEV_HI        22
`define FRM_DEV_LO        21
`define FRM_RSEL_HI       20
`define FRM_RSEL_LO       18
`define FRM_CH_HI         17
`define FRM_CH_LO         16
`define FRM_DATA_HI       15
`define FRM_SUB_HI        15
`define FRM_SUB_LO        13
`define FRM_VAL_HI        15
`define FRM_VAL_LO        4

// register select codes
`define RSEL_DATA         3'h0
`define RSEL_GAIN_ONE     3'h2
`define RSEL_GAIN_ALL     3'h3
`define RSEL_OFFS_ONE     3'h4
`define RSEL_OFFS_ALL     3'h5
`define RSEL_CLR_ONE      3'h6
`define RSEL_CONTROL      3'h7

// control sub-select codes
`define SUB_SLEW          3'h0
`define SUB_MAIN          3'h1
`define SUB_CHAN_CFG      3'h2
`define SUB_SUPPLY        3'h3
`define SUB_SOFTWARE      3'h4

// main control fields
`define MAIN_STATUS_READBACK_ENABLE_BIT 11
`define MAIN_WDEN_BIT     10
`define MAIN_WDSEL_HI     9
`define MAIN_WDSEL_LO     8
`define MAIN_OUTEN_BIT    5
`define MAIN_DCDC_BIT     4
`define MAIN_KEEP_MASK    16'h0f30

// channel configuration field
`define CFG_CLEAR_ENABLE_BIT    7

// low nibbles that the host fills in
`define GAIN_LOW_FILL     4'hf
`define OFFS_LOW_FILL     4'h0

// reset values
`define GAIN_RESET        16'hffff
`define OFFS_RESET        16'h8000
`define CLR_RESET         16'h0000
`define MAIN_RESET        16'h0000
`define CFG_RESET         16'h0000

// watchdog periods in ms and clock rate in kHz
`define CLK_KHZ           200000
`define WD_MS_0           5
`define WD_MS_1           10
`define WD_MS_2           100
`define WD_MS_3           200
`define WD_CYC_0          (`WD_MS_0 * `CLK_KHZ)
`define WD_CYC_1          (`WD_MS_1 * `CLK_KHZ)
`define WD_CYC_2          (`WD_MS_2 * `CLK_KHZ)
`define WD_CYC_3          (`WD_MS_3 * `CLK_KHZ)

// host serial clock divider: one bit per this many cycles
`define HOST_BIT_DIV      4

`endif

// *** logic/trim_ctrl_pkg.sv ***
// trim_ctrl_pkg.sv: types shared by both ends of the trim register link
// assumes: trim_ctrl_map.svh on the include path
`default_nettype none
`include "trim_ctrl_map.svh"

package trim_ctrl_pkg;

  typedef logic [`FRAME_BITS-1:0] frame_t;
  typedef logic [15:0]            reg16_t;
  typedef logic [1:0]             chan_t;

endpackage : trim_ctrl_pkg

`default_nettype wire

// *** logic/trim_device.sv ***
// trim_device.sv: device end, decodes serial frames into trim and control regs
// assumes: host keeps sync_n low for exactly 24 strobes per frame
`timescale 1ns/1ps
`default_nettype none
`include "trim_ctrl_map.svh"

module trim_device #(
  parameter int unsigned NUM_CH   = 4,
  parameter int unsigned WD_CYC_0 = `WD_CYC_0,
  parameter int unsigned WD_CYC_1 = `WD_CYC_1,
  parameter int unsigned WD_CYC_2 = `WD_CYC_2,
  parameter int unsigned WD_CYC_3 = `WD_CYC_3
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   address_strap_hi,
  input  wire logic                   address_strap_lo,
  input  wire logic                   clear_in,
  trim_link_if.device                 link,
  output trim_ctrl_pkg::reg16_t       channel_gain_trim   [NUM_CH],
  output trim_ctrl_pkg::reg16_t       channel_offset_trim [NUM_CH],
  output trim_ctrl_pkg::reg16_t       channel_clear_value [NUM_CH],
  output trim_ctrl_pkg::reg16_t       global_main_control,
  output logic [NUM_CH-1:0]           clear_force,
  output logic                        status_readback_enable,
  output logic                        watchdog_enable,
  output logic [1:0]                  timeout_select,
  output logic [31:0]                 watchdog_period,
  output logic                        all_outputs_enable,
  output logic                        all_supply_power_up,
  output logic                        read_request,
  output logic                        frame_done
);
  import trim_ctrl_pkg::*;

  frame_t     shift_reg, shift_next;
  logic [4:0] count_reg, count_next;
  logic       done_reg,  done_next;
  logic       rd_reg,    rd_next;

  reg16_t gain_reg [NUM_CH];
  reg16_t offs_reg [NUM_CH];
  reg16_t clr_reg  [NUM_CH];
  reg16_t cfg_reg  [NUM_CH];
  reg16_t gain_next [NUM_CH];
  reg16_t offs_next [NUM_CH];
  reg16_t clr_next  [NUM_CH];
  reg16_t cfg_next  [NUM_CH];
  reg16_t main_reg, main_next;
  logic [NUM_CH-1:0] force_reg, force_next;
  logic [31:0] period_reg, period_next;

  // decoded fields of the last full frame
  logic       addr_ok;
  logic       is_write;
  logic [2:0] rsel;
  logic [2:0] sub;
  chan_t      chan;
  reg16_t     value16;
  reg16_t     payload;

  // ****************************************************************
  // serial receiver
  // ****************************************************************

  // shift on strobe while framed, flag when bit 24 lands
  always_comb begin
    shift_next = shift_reg;
    count_next = count_reg;
    done_next  = 1'b0;
    if (link.sync_n) begin
      count_next = 5'h0;
    end else if (link.sclk_en) begin
      shift_next = {shift_reg[`FRAME_BITS-2:0], link.sdata};
      count_next = count_reg + 5'h1;
      if (count_reg == 5'(`FRAME_BITS - 1)) begin
        done_next  = 1'b1;
        count_next = 5'h0;
      end
    end
  end

  // register receiver state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_reg <= '0;
      count_reg <= 5'h0;
      done_reg  <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      count_reg <= count_next;
      done_reg  <= done_next;
    end
  end

  // ****************************************************************
  // frame decode and register writes
  // ****************************************************************

  // field extraction from completed frame
  assign addr_ok  = (shift_reg[`FRM_DEV_HI] == address_strap_hi) &&
                    (shift_reg[`FRM_DEV_LO] == address_strap_lo);
  assign is_write = ~shift_reg[`FRM_RW_BIT];
  assign rsel     = shift_reg[`FRM_RSEL_HI:`FRM_RSEL_LO];
  assign sub      = shift_reg[`FRM_SUB_HI:`FRM_SUB_LO];
  assign chan     = shift_reg[`FRM_CH_HI:`FRM_CH_LO];
  assign value16  = shift_reg[`FRM_DATA_HI:0];
  assign payload  = {3'h0, shift_reg[12:0]};

  // next values of all register banks
  always_comb begin
    main_next = main_reg;
    rd_next   = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      gain_next[i] = gain_reg[i];
      offs_next[i] = offs_reg[i];
      clr_next[i]  = clr_reg[i];
      cfg_next[i]  = cfg_reg[i];
    end
    if (done_reg && addr_ok) begin
      rd_next = ~is_write;
      if (is_write) begin
        for (int i = 0; i < NUM_CH; i++) begin
          case (rsel)
            `RSEL_GAIN_ONE: if (chan == 2'(i)) gain_next[i] = value16;
            `RSEL_GAIN_ALL: gain_next[i] = value16;
            `RSEL_OFFS_ONE: if (chan == 2'(i)) offs_next[i] = value16;
            `RSEL_OFFS_ALL: offs_next[i] = value16;
            `RSEL_CLR_ONE:  if (chan == 2'(i)) clr_next[i] = value16;
            `RSEL_CONTROL: begin
              if (sub == `SUB_CHAN_CFG && chan == 2'(i)) cfg_next[i] = payload;
            end
            default: ;
          endcase
        end
        if (rsel == `RSEL_CONTROL && sub == `SUB_MAIN) begin
          main_next = payload & `MAIN_KEEP_MASK;
        end
      end
    end
  end

  // per-channel register storage
  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          gain_reg[g] <= `GAIN_RESET;
          offs_reg[g] <= `OFFS_RESET;
          clr_reg[g]  <= `CLR_RESET;
          cfg_reg[g]  <= `CFG_RESET;
        end else begin
          gain_reg[g] <= gain_next[g];
          offs_reg[g] <= offs_next[g];
          clr_reg[g]  <= clr_next[g];
          cfg_reg[g]  <= cfg_next[g];
        end
      end
      assign channel_gain_trim[g]   = gain_reg[g];
      assign channel_offset_trim[g] = offs_reg[g];
      assign channel_clear_value[g] = clr_reg[g];
    end
  endgenerate

  // ****************************************************************
  // main control, clear gating, watchdog period
  // ****************************************************************

  // clear gating and timeout decode
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      force_next[i] = clear_in & cfg_reg[i][`CFG_CLEAR_ENABLE_BIT];
    end
    case (main_reg[`MAIN_WDSEL_HI:`MAIN_WDSEL_LO])
      2'h0:    period_next = WD_CYC_0;
      2'h1:    period_next = WD_CYC_1;
      2'h2:    period_next = WD_CYC_2;
      2'h3:    period_next = WD_CYC_3;
      default: period_next = WD_CYC_0;
    endcase
  end

  // register main control and derived outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_reg   <= `MAIN_RESET;
      force_reg  <= '0;
      period_reg <= WD_CYC_0;
      rd_reg     <= 1'b0;
    end else begin
      main_reg   <= main_next;
      force_reg  <= force_next;
      period_reg <= period_next;
      rd_reg     <= rd_next;
    end
  end

  assign global_main_control    = main_reg;
  assign status_readback_enable = main_reg[`MAIN_STATUS_READBACK_ENABLE_BIT];
  assign watchdog_enable        = main_reg[`MAIN_WDEN_BIT];
  assign timeout_select         = main_reg[`MAIN_WDSEL_HI:`MAIN_WDSEL_LO];
  assign all_outputs_enable     = main_reg[`MAIN_OUTEN_BIT];
  assign all_supply_power_up    = main_reg[`MAIN_DCDC_BIT];
  assign clear_force            = force_reg;
  assign watchdog_period        = period_reg;
  assign read_request           = rd_reg;
  assign frame_done             = done_reg;

endmodule : trim_device

`default_nettype wire

// *** logic/trim_host.sv ***
// trim_host.sv: host end, shifts one 24-bit frame per request onto the link
// assumes: requester holds frame stable while start is high and busy is low
`timescale 1ns/1ps
`default_nettype none
`include "trim_ctrl_map.svh"

module trim_host (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  start,
  input  wire trim_ctrl_pkg::frame_t frame,
  output logic                       busy,
  trim_link_if.host                  link
);
  import trim_ctrl_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} host_state_t;

  host_state_t state_reg, state_next;
  frame_t      shift_reg, shift_next;
  logic [4:0]  bits_reg,  bits_next;
  logic [2:0]  div_reg,   div_next;
  logic        sdata_reg, sdata_next;
  logic        sync_n_reg, sync_n_next;
  logic        strobe_reg, strobe_next;
  logic        busy_reg,   busy_next;

  // ****************************************************************
  // frame shifter
  // ****************************************************************

  // next state of shifter; frame content is the requester's job
  always_comb begin
    state_next  = state_reg;
    shift_next  = shift_reg;
    bits_next   = bits_reg;
    div_next    = div_reg;
    sdata_next  = sdata_reg;
    sync_n_next = sync_n_reg;
    strobe_next = 1'b0;
    case (state_reg)
      H_IDLE: begin
        if (start) begin
          shift_next  = frame;
          sync_n_next = 1'b0;
          bits_next   = 5'h0;
          div_next    = 3'h0;
          sdata_next  = frame[`FRAME_BITS-1];
          state_next  = H_SHIFT;
        end
      end
      H_SHIFT: begin
        // next bit only after the device has taken the current one
        if (strobe_reg) sdata_next = shift_reg[`FRAME_BITS-1];
        div_next = div_reg + 3'h1;
        if (div_reg == 3'(`HOST_BIT_DIV - 1)) begin
          div_next    = 3'h0;
          strobe_next = 1'b1;
          shift_next  = {shift_reg[`FRAME_BITS-2:0], 1'b0};
          bits_next   = bits_reg + 5'h1;
          if (bits_reg == 5'(`FRAME_BITS - 1)) begin
            state_next = H_GAP;
          end
        end
      end
      H_GAP: begin
        sync_n_next = 1'b1; // close frame after last strobe
        state_next  = H_IDLE;
      end
      default: state_next = H_IDLE;
    endcase
    busy_next = (state_next != H_IDLE); // busy as a flop, same timing as state
  end

  // register shifter state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg  <= H_IDLE;
      shift_reg  <= '0;
      bits_reg   <= 5'h0;
      div_reg    <= 3'h0;
      sdata_reg  <= 1'b0;
      sync_n_reg <= 1'b1;
      strobe_reg <= 1'b0;
      busy_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      shift_reg  <= shift_next;
      bits_reg   <= bits_next;
      div_reg    <= div_next;
      sdata_reg  <= sdata_next;
      sync_n_reg <= sync_n_next;
      strobe_reg <= strobe_next;
      busy_reg   <= busy_next;
    end
  end

  assign link.sclk_en = strobe_reg;
  assign link.sdata   = sdata_reg;
  assign link.sync_n  = sync_n_reg;
  assign busy         = busy_reg;

endmodule : trim_host

`default_nettype wire

// *** logic/trim_link_if.sv ***
// trim_link_if.sv: three-wire serial write link between host and device
// assumes: one shared clock; the host drives every wire
`timescale 1ns/1ps
`default_nettype none

interface trim_link_if;
  logic sclk_en;  // one-cycle bit strobe
  logic sdata;    // serial data, msb first
  logic sync_n;   // frame active low

  modport host   (output sclk_en, output sdata, output sync_n);
  modport device (input  sclk_en, input  sdata, input  sync_n);
endinterface : trim_link_if

`default_nettype wire

// *** sim/tb_top.sv ***
// tb_top.sv: host and device ends joined on one link, registers judged at device
// assumes: design files and package compiled first, one 200 MHz clock
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import trim_ctrl_pkg::*;
  localparam logic [1:0] DEV = 2'h2;
  logic clk, sys_rst, start, clear_in, busy;
  logic st_o, wd_o, out_o, sup_o, rd_o, done_o;
  logic [1:0] strap, tsel_o;
  logic [3:0] force_o;
  logic [31:0] wdp_o;
  frame_t frame;
  reg16_t gain_o [4], offs_o [4], clr_o [4], main_o;
  reg16_t g_exp [4], o_exp [4], c_exp [4];
  int error_cnt = 0, n_compared = 0, rd_cnt = 0, done_cnt = 0;

  trim_link_if link_i ();
  trim_host u_trim_host (.clk(clk), .sys_rst(sys_rst), .start(start), .frame(frame),
    .busy(busy), .link(link_i));
  trim_device #(.NUM_CH(4), .WD_CYC_0(10), .WD_CYC_1(20), .WD_CYC_2(30), .WD_CYC_3(40))
    u_trim_device (.clk(clk), .sys_rst(sys_rst), .address_strap_hi(strap[1]),
    .address_strap_lo(strap[0]), .clear_in(clear_in), .link(link_i),
    .channel_gain_trim(gain_o), .channel_offset_trim(offs_o), .channel_clear_value(clr_o),
    .global_main_control(main_o), .clear_force(force_o), .status_readback_enable(st_o),
    .watchdog_enable(wd_o), .timeout_select(tsel_o), .watchdog_period(wdp_o),
    .all_outputs_enable(out_o), .all_supply_power_up(sup_o), .read_request(rd_o),
    .frame_done(done_o));
  trim_link_chk u_trim_link_chk (.clk(clk), .sys_rst(sys_rst), .sclk_en(link_i.sclk_en),
    .sdata(link_i.sdata), .sync_n(link_i.sync_n));

  // *******************
  // shared helpers
  // *******************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // read and frame-done pulses counted as they pass
  always @(posedge clk) begin
    if (rd_o === 1'b1) rd_cnt <= rd_cnt + 1;
    if (done_o === 1'b1) done_cnt <= done_cnt + 1;
  end

  task automatic wrap_up;
    $display("compared %0d, wrong %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic frame_t mk(input logic rw, input logic [2:0] rs, input logic [1:0] ch,
                                input logic [15:0] d);
    return {rw, DEV, rs, ch, d};
  endfunction : mk

  // one frame through the host, bounded waits on busy
  task automatic send(input frame_t f);
    int i;
    @(posedge clk) begin start <= 1'b1; frame <= f; end
    for (i = 0; i < 10 && busy !== 1'b1; i++) @(negedge clk);
    check(busy, 32'h1);
    @(posedge clk) start <= 1'b0;
    for (i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk);
    check(busy, 32'h0);
    if (busy !== 1'b0) wrap_up;
    repeat (2) @(negedge clk);
  endtask : send

  task automatic check_all;
    for (int c = 0; c < 4; c++) begin
      check(gain_o[c], g_exp[c]);
      check(offs_o[c], o_exp[c]);
      check(clr_o[c], c_exp[c]);
    end
  endtask : check_all

  task automatic wr(input logic [2:0] rs, input logic [1:0] ch, input logic [15:0] v);
    send(mk(1'b0, rs, ch, v));
    case (rs)
      3'h2: g_exp[ch] = v;
      3'h3: foreach (g_exp[k]) g_exp[k] = v;
      3'h4: o_exp[ch] = v;
      3'h5: foreach (o_exp[k]) o_exp[k] = v;
      3'h6: c_exp[ch] = v;
      default: ;
    endcase
    check_all;
  endtask : wr

  // *******************
  // scenarios
  // *******************
  task automatic t_reset;
    @(posedge clk) sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    foreach (g_exp[k]) begin
      g_exp[k] = 16'hffff;
      o_exp[k] = 16'h8000;
      c_exp[k] = 16'h0000;
    end
    check_all;
    check(main_o, 16'h0000);
    check(wdp_o, 32'ha);
    $display("reset test done");
  endtask : t_reset

  task automatic t_regs;
    for (int c = 0; c < 4; c++) begin
      wr(3'h2, c[1:0], {2'h3, c[1:0], 8'ha3, 4'hf});
      wr(3'h4, c[1:0], {2'h2, c[1:0], 8'h5c, 4'h0});
      wr(3'h6, c[1:0], {2'h3, c[1:0], 8'h96, 4'h0});
    end
    wr(3'h3, 2'h2, 16'h9c5f);
    wr(3'h5, 2'h1, 16'h0000);
    wr(3'h4, 2'h3, 16'hfff0);
    wr(3'h6, 2'h0, 16'hfff0);
    $display("register write test done");
  endtask : t_regs

  task automatic t_refused;
    int n, d;
    d = done_cnt;
    send(mk(1'b0, 3'h2, 2'h0, 16'h777f) ^ 24'h200000);
    check(done_cnt - d, 1);
    check_all;
    wr(3'h0, 2'h1, 16'h1230);
    wr(3'h1, 2'h2, 16'h4560);
    wr(3'h7, 2'h0, 16'h1fff);
    wr(3'h7, 2'h0, 16'h7fff);
    wr(3'h7, 2'h0, 16'h9fff);
    check(main_o, 16'h0000);
    n = rd_cnt;
    wr(3'h2, 2'h1, 16'hc00f);
    check(rd_cnt - n, 0);
    send(mk(1'b1, 3'h2, 2'h1, 16'h000f));
    check(rd_cnt - n, 1);
    check_all;
    send(mk(1'b1, 3'h2, 2'h1, 16'h000f) ^ 24'h400000);
    check(rd_cnt - n, 1);
    $display("refused frame test done");
  endtask : t_refused

  task automatic t_main;
    for (int c = 0; c < 4; c++) begin
      logic [1:0] k;
      k = c[1:0];
      send(mk(1'b0, 3'h7, 2'h3, {3'h1, 1'b1, k[0], k[1], k, 2'h3, ~k[0], ~k[1], 4'ha}));
      check(main_o, {4'h0, k[0], k[1], k, 2'h0, ~k[0], ~k[1], 4'h0});
      check({st_o, wd_o, tsel_o, out_o, sup_o}, {k[0], k[1], k, ~k[0], ~k[1]});
      check(wdp_o, 10 * (c + 1));
    end
    $display("main control test done");
  endtask : t_main

  task automatic t_clear;
    for (int p = 0; p < 2; p++) begin
      if (p == 1) send(mk(1'b0, 3'h7, 2'h1, 16'h4080));
      @(posedge clk) clear_in <= 1'b1;
      repeat (3) @(negedge clk);
      check(force_o, (p == 1) ? 4'h2 : 4'h0);
      @(posedge clk) clear_in <= 1'b0;
      repeat (3) @(negedge clk);
      check(force_o, 4'h0);
    end
    $display("clear test done");
  endtask : t_clear

  initial begin
    sys_rst = 1'b1;
    start = 1'b0;
    frame = '0;
    clear_in = 1'b0;
    strap = DEV;
    t_reset;
    t_regs;
    t_refused;
    t_main;
    t_clear;
    t_reset;
    wrap_up;
  end
endmodule : tb_top

`default_nettype wire

// *** sim/trim_link_chk.sv ***
// trim_link_chk.sv: wire-level checks on the serial trim link
// assumes: instantiated beside the link interface, one clock domain
`timescale 1ns/1ps
`default_nettype none

module trim_link_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk_en,
  input wire logic sdata,
  input wire logic sync_n
);
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;

  // ****************
  // strobe counter
  // ****************
  // strobes seen in the current frame
  always_comb begin
    cnt_next = cnt_reg;
    if (sync_n) cnt_next = 5'h0;
    else if (sclk_en) cnt_next = cnt_reg + 5'h1;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) cnt_reg <= 5'h0;
    else cnt_reg <= cnt_next;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  idle_after_reset_a:
    assert property ($fell(sys_rst) |-> sync_n && !sclk_en)
      else $error("link busy right after reset");
  strobe_in_frame_a:
    assert property (sclk_en |-> !sync_n)
      else $error("strobe outside a frame");
  strobe_gap_a:
    assert property (sclk_en |=> !sclk_en [*3])
      else $error("strobes closer than four cycles");
  first_strobe_a:
    assert property ($fell(sync_n) |-> !sclk_en [*4] ##1 sclk_en)
      else $error("first strobe not four cycles after frame start");
  frame_span_a:
    assert property ($fell(sync_n) |-> ##97 $rose(sync_n))
      else $error("frame not 97 cycles long");
  strobe_count_a:
    assert property ($rose(sync_n) |-> cnt_reg == 5'h18)
      else $error("frame ended without 24 strobes");
  end_after_last_a:
    assert property (sclk_en && cnt_reg == 5'h17 |=> $rose(sync_n))
      else $error("frame not closed after last strobe");
  no_extra_strobe_a:
    assert property (sclk_en |-> cnt_reg < 5'h18)
      else $error("more than 24 strobes in a frame");
  data_hold_a:
    assert property (!sync_n && !sclk_en && !$past(sclk_en) && !$past(sync_n) |-> $stable(sdata))
      else $error("data moved between strobes");

  frame_seen_c: cover property ($rose(sync_n));
  last_strobe_c: cover property (sclk_en && cnt_reg == 5'h17);
  back_to_back_c: cover property ($rose(sync_n) ##[1:4] $fell(sync_n));
endmodule : trim_link_chk

`default_nettype wire
